// *** design/e1ox_params.svh ***
// register map, field positions and fixed codes of the overhead block
`ifndef E1OX_PARAMS_SVH
`define E1OX_PARAMS_SVH
`define E1OX_AW         8
`define E1OX_A_CTRL     8'h00
`define E1OX_A_STAT     8'h04
`define E1OX_A_FLAG0    8'h08
`define E1OX_A_ENA0     8'h0C
`define E1OX_A_FLAG1    8'h10
`define E1OX_A_ENA1     8'h14
`define E1OX_A_OVH      8'h18
`define E1OX_A_SA6IND   8'h1C
`define E1OX_A_CW4      8'h20
`define E1OX_A_CW8      8'h30
`define E1OX_C_PESEL    0
`define E1OX_C_AZSEL    1
`define E1OX_C_AUTO_REFRAME_ENABLE    2
`define E1OX_C_DEB      3
`define E1OX_C_SA6SEL   4
`define E1OX_CTRL_W     5
`define E1OX_F1_COFA    0
`define E1OX_F1_FASE    1
`define E1OX_F1_CRCPE   2
`define E1OX_F1_CASPE   3
`define E1OX_F1_CRC4    4
`define E1OX_F1_FEBE    5
`define E1OX_F1_NTFEBE  6
`define E1OX_F1_NTCRC   7
`define E1OX_F1_CMF     8
`define E1OX_F1_CSMF    9
`define E1OX_F1_SMF     10
`define E1OX_F1_SA6     11
`define E1OX_F1_CW      16
`define E1OX_F1_W       21
`define E1OX_TS_OVH     5'h00
`define E1OX_TS_CAS     5'h10
`define E1OX_BIT_FIRST  3'h0
`define E1OX_BIT_LAST   3'h7
`define E1OX_SUB_FIRST  3'h0
`define E1OX_SUB_LAST   3'h7
`define E1OX_MF_FIRST   4'h0
`define E1OX_MF_LAST    4'hF
`define E1OX_CAS_PAT    4'h0
`define E1OX_CODE_A     12'h888
`define E1OX_CODE_B     12'hAAA
`define E1OX_CODE_C     12'hCCC
`define E1OX_CODE_D     12'hEEE
`define E1OX_CODE_E     12'hFFF
`define E1OX_RESP_OK    2'h0
`define E1OX_RESP_ERR   2'h2
`endif

// *** design/e1ox_pkg.sv ***
// types shared by the overhead block
package e1ox_pkg;
  typedef enum logic {CAS_LOST, CAS_SYNC} e1ox_cas_t;
endpackage : e1ox_pkg

// *** design/e1ox_overhead.sv ***
// e1 receive overhead extraction, cas alignment and interrupt gathering
//
// The register offsets and register access over AXI4-Lite were decided locally.
`include "e1ox_params.svh"
module e1ox_overhead
  import e1ox_pkg::*;
(
  input  wire logic                  REF_CLK,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic                  RX_BIT,
  input  wire logic                  RX_BIT_VALID,
  input  wire logic [4:0]            FRM_TS,
  input  wire logic [2:0]            FRM_BITPOS,
  input  wire logic [3:0]            FRM_NUM,
  input  wire logic                  FRAME_LOSS,
  input  wire logic                  CRC_MF_LOSS,
  input  wire logic                  INTERWORK,
  input  wire logic                  OFFLINE_SEARCH,
  input  wire logic                  CONT_RAI_FEBE,
  input  wire logic                  CONT_FEBE,
  input  wire logic                  ALIGN_CHANGE,
  input  wire logic                  FAS_ERR,
  input  wire logic                  CRC_PAT_ERR,
  input  wire logic                  CRC4_ERR,
  input  wire logic                  FEBE_ERR,
  input  wire logic                  NT_FEBE_ERR,
  input  wire logic                  NT_CRC_ERR,
  output logic                       INT_N,
  input  wire logic [`E1OX_AW-1:0]   S_AXI_AWADDR,
  input  wire logic                  S_AXI_AWVALID,
  output logic                       S_AXI_AWREADY,
  input  wire logic [31:0]           S_AXI_WDATA,
  input  wire logic [3:0]            S_AXI_WSTRB,
  input  wire logic                  S_AXI_WVALID,
  output logic                       S_AXI_WREADY,
  output logic [1:0]                 S_AXI_BRESP,
  output logic                       S_AXI_BVALID,
  input  wire logic                  S_AXI_BREADY,
  input  wire logic [`E1OX_AW-1:0]   S_AXI_ARADDR,
  input  wire logic                  S_AXI_ARVALID,
  output logic                       S_AXI_ARREADY,
  output logic [31:0]                S_AXI_RDATA,
  output logic [1:0]                 S_AXI_RRESP,
  output logic                       S_AXI_RVALID,
  input  wire logic                  S_AXI_RREADY
);
  function automatic logic [4:0] code_hits(input logic [11:0] w);
    code_hits = {w == `E1OX_CODE_E, w == `E1OX_CODE_D, w == `E1OX_CODE_C,
                 w == `E1OX_CODE_B, w == `E1OX_CODE_A};
  endfunction : code_hits
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask
  function automatic logic map_ok(input logic [`E1OX_AW-1:0] a);
    map_ok = (a <= `E1OX_A_CW8);
  endfunction : map_ok
  logic [`E1OX_CTRL_W-1:0] ctrl_ff;
  logic [7:0]              ena0_ff;
  logic [`E1OX_F1_W-1:0]   ena1_ff;
  logic [7:0]              flag0_ff;
  logic [`E1OX_F1_W-1:0]   flag1_ff;
  logic [4:0]              sa6ind_ff;
  logic [7:0]              stat_ff;
  logic [6:0]              ts0_sh_ff;
  logic [6:0]              ts16_sh_ff;
  logic [1:0]              si_ff;
  logic                    a_ff;
  logic [4:0]              sa_ff;
  logic [3:0]              cw_sh_ff   [5];
  logic [3:0]              cw_cand_ff [5];
  logic [3:0]              cw_ff      [5];
  logic [11:0]             sa6_sh_ff;
  logic [1:0]              sa7_sh_ff;
  logic                    link_ff;
  e1ox_cas_t               cas_ff;
  logic [3:0]              cas_frm_ff;
  logic                    prev_zero_ff;
  logic                    az_run_ff;
  logic [3:0]              xy_sh_ff;
  logic [2:0]              x_ff;
  logic                    y_ff;
  logic                    aw_held_ff, w_held_ff, awready_ff, wready_ff;
  logic [`E1OX_AW-1:0]     aw_addr_ff;
  logic [31:0]             w_data_ff;
  logic [3:0]              w_strb_ff;
  logic                    bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]              bresp_ff, rresp_ff;
  logic [31:0]             rdata_ff;
  logic                    int_n_ff;
  logic                    nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid, do_wr, rd_acc;
  logic [31:0]             wmask, lmask;
  // stream position decode
  logic        in_ts0, in_ts16, frame_start, ts0_end, ts16_end, nfas_end, submf_end;
  logic        basic_ok, crc_ok, sa6_sync, sa6_cmp;
  logic [7:0]  ts0_byte, ts16_byte;
  logic [11:0] sa6_win;
  logic [4:0]  sa6_hit, cw_chg;
  logic [3:0]  cw_new [5];
  logic        cas_pat_err, cas_az_loss, cas_start;
  logic [7:0]  stat_now;
  logic [`E1OX_F1_W-1:0] ev1;
  assign basic_ok    = ~FRAME_LOSS;
  assign crc_ok      = ~CRC_MF_LOSS;
  assign in_ts0      = RX_BIT_VALID & (FRM_TS == `E1OX_TS_OVH);
  assign in_ts16     = RX_BIT_VALID & (FRM_TS == `E1OX_TS_CAS);
  assign frame_start = in_ts0 & (FRM_BITPOS == `E1OX_BIT_FIRST);
  assign ts0_end     = in_ts0 & (FRM_BITPOS == `E1OX_BIT_LAST);
  assign ts16_end    = in_ts16 & (FRM_BITPOS == `E1OX_BIT_LAST);
  assign ts0_byte    = {ts0_sh_ff, RX_BIT};
  assign ts16_byte   = {ts16_sh_ff, RX_BIT};
  assign nfas_end    = ts0_end & FRM_NUM[0] & basic_ok;
  assign submf_end   = nfas_end & (FRM_NUM[2:0] == `E1OX_SUB_LAST);
  assign sa6_win     = {sa6_sh_ff[10:0], ts0_byte[2]};
  assign sa6_sync    = ctrl_ff[`E1OX_C_SA6SEL] & crc_ok;
  // in aligned mode the window is three whole codewords only at sub mf end
  assign sa6_cmp     = nfas_end & (~sa6_sync | submf_end);
  assign sa6_hit     = code_hits(sa6_win) & {5{sa6_cmp}};
  // cas frame 0 and frame 15 checks; no pattern error while cas is lost
  assign cas_pat_err = (cas_ff == CAS_SYNC) & ts16_end &
                       (cas_frm_ff == `E1OX_MF_FIRST) &
                       (ts16_byte[7:4] != `E1OX_CAS_PAT);
  assign cas_az_loss = (cas_ff == CAS_SYNC) & ts16_end & (cas_frm_ff == `E1OX_MF_LAST) &
                       az_run_ff & (ts16_byte == 8'h00);
  assign cas_start   = (cas_ff == CAS_SYNC) & frame_start & (cas_frm_ff == `E1OX_MF_LAST);
  always_comb begin
    cw_chg = 5'h00;
    for (int i = 0; i < 5; i++) begin
      cw_new[i] = {cw_sh_ff[i][2:0], ts0_byte[4-i]};
      if (submf_end & crc_ok &
          (~ctrl_ff[`E1OX_C_DEB] | (cw_new[i] == cw_cand_ff[i])) &
          (cw_new[i] != cw_ff[i])) begin
        cw_chg[i] = 1'b1;
      end
    end
  end
  assign stat_now = {link_ff, CONT_FEBE, CONT_RAI_FEBE, OFFLINE_SEARCH,
                     (cas_ff == CAS_LOST) | FRAME_LOSS,
                     CRC_MF_LOSS, FRAME_LOSS, INTERWORK};
  always_comb begin
    ev1                   = '0;
    ev1[`E1OX_F1_COFA]    = ALIGN_CHANGE;
    ev1[`E1OX_F1_FASE]    = FAS_ERR;
    ev1[`E1OX_F1_CRCPE]   = CRC_PAT_ERR;
    ev1[`E1OX_F1_CASPE]   = cas_pat_err;
    ev1[`E1OX_F1_CRC4]    = CRC4_ERR;
    ev1[`E1OX_F1_FEBE]    = FEBE_ERR;
    ev1[`E1OX_F1_NTFEBE]  = NT_FEBE_ERR;
    ev1[`E1OX_F1_NTCRC]   = NT_CRC_ERR;
    ev1[`E1OX_F1_CMF]     = frame_start & crc_ok & (FRM_NUM == `E1OX_MF_FIRST);
    ev1[`E1OX_F1_CSMF]    = frame_start & crc_ok & (FRM_NUM[2:0] == `E1OX_SUB_FIRST);
    ev1[`E1OX_F1_SMF]     = cas_start;
    ev1[`E1OX_F1_SA6]     = |sa6_hit;
    ev1[`E1OX_F1_CW+:5]   = cw_chg;
  end
  // ts0 overhead
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ts0_sh_ff <= '0;
      si_ff     <= '0;
      a_ff      <= 1'b0;
      sa_ff     <= '0;
    end else if (CE) begin
      if (in_ts0) ts0_sh_ff <= ts0_byte[6:0];
      if (ts0_end & basic_ok) si_ff[FRM_NUM[0]] <= ts0_byte[7];
      if (nfas_end) begin
        a_ff  <= ts0_byte[5];
        sa_ff <= ts0_byte[4:0];
      end
    end
  end
  // sa codewords
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      for (int i = 0; i < 5; i++) begin
        cw_sh_ff[i]   <= '0;
        cw_cand_ff[i] <= '0;
        cw_ff[i]      <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < 5; i++) begin
        if (nfas_end) cw_sh_ff[i] <= cw_new[i];
        if (submf_end & crc_ok) cw_cand_ff[i] <= cw_new[i];
        if (cw_chg[i]) cw_ff[i] <= cw_new[i];
      end
    end
  end
  // sa6 code window and v5.2 link id
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sa6_sh_ff <= '0;
      sa7_sh_ff <= '0;
      link_ff   <= 1'b0;
    end else if (CE) begin
      if (nfas_end) begin
        sa6_sh_ff <= sa6_win;
        sa7_sh_ff <= {sa7_sh_ff[0], ts0_byte[1]};
        link_ff   <= ({1'b0, ~sa7_sh_ff[1]} + {1'b0, ~sa7_sh_ff[0]} +
                      {1'b0, ~ts0_byte[1]}) >= 2'd2;
      end else if (~basic_ok) begin
        link_ff   <= 1'b0;
      end
    end
  end
  // cas multi-frame alignment and ts16 spare bits
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cas_ff       <= CAS_LOST;
      cas_frm_ff   <= '0;
      ts16_sh_ff   <= '0;
      prev_zero_ff <= 1'b0;
      az_run_ff    <= 1'b0;
      xy_sh_ff     <= '0;
      x_ff         <= '0;
      y_ff         <= 1'b0;
    end else if (CE) begin
      if (in_ts16) ts16_sh_ff <= ts16_byte[6:0];
      if (ts16_end) prev_zero_ff <= (ts16_byte[7:4] == `E1OX_CAS_PAT);
      if (cas_start) begin
        x_ff <= xy_sh_ff[2:0];
        y_ff <= xy_sh_ff[3];
      end
      case (cas_ff)
        CAS_LOST: begin
          // search ignores the auto-reframe bit on purpose
          if (basic_ok & ts16_end & (ts16_byte[7:4] == `E1OX_CAS_PAT) &
              ~prev_zero_ff) begin
            cas_ff     <= CAS_SYNC;
            cas_frm_ff <= `E1OX_MF_FIRST;
            az_run_ff  <= (ts16_byte == 8'h00);
            xy_sh_ff   <= {ts16_byte[2], ts16_byte[3], ts16_byte[1], ts16_byte[0]};
          end
        end
        CAS_SYNC: begin
          if (frame_start) cas_frm_ff <= cas_frm_ff + 4'h1;
          if (ts16_end) begin
            if (cas_frm_ff == `E1OX_MF_FIRST) begin
              az_run_ff <= (ts16_byte == 8'h00);
              if (~cas_pat_err) begin
                xy_sh_ff <= {ts16_byte[2], ts16_byte[3], ts16_byte[1], ts16_byte[0]};
              end
            end else if (ts16_byte != 8'h00) begin
              az_run_ff <= 1'b0;
            end
          end
          if (~basic_ok |
              (cas_pat_err & ctrl_ff[`E1OX_C_PESEL]) |
              (cas_az_loss & ctrl_ff[`E1OX_C_AZSEL])) begin
            cas_ff <= CAS_LOST;
          end
        end
        default: cas_ff <= CAS_LOST;
      endcase
    end
  end
  // axi4-lite handshake
  always_comb begin
    nxt_aw_held = aw_held_ff | (S_AXI_AWVALID & awready_ff);
    nxt_w_held  = w_held_ff | (S_AXI_WVALID & wready_ff);
    do_wr       = aw_held_ff & w_held_ff & ~bvalid_ff;
    if (do_wr) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
    end
    nxt_bvalid  = do_wr | (bvalid_ff & ~S_AXI_BREADY);
    rd_acc      = S_AXI_ARVALID & arready_ff;
    nxt_rvalid  = rd_acc | (rvalid_ff & ~S_AXI_RREADY);
    lmask       = lane_mask(w_strb_ff);
    wmask       = do_wr ? (w_data_ff & lmask) : 32'h0;
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= '0;
      w_strb_ff  <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `E1OX_RESP_OK;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `E1OX_RESP_OK;
      rdata_ff   <= '0;
    end else if (CE) begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held;
      wready_ff  <= ~nxt_w_held;
      if (S_AXI_AWVALID & awready_ff) aw_addr_ff <= S_AXI_AWADDR;
      if (S_AXI_WVALID & wready_ff) begin
        w_data_ff <= S_AXI_WDATA;
        w_strb_ff <= S_AXI_WSTRB;
      end
      bvalid_ff  <= nxt_bvalid;
      if (do_wr) bresp_ff <= map_ok(aw_addr_ff) ? `E1OX_RESP_OK : `E1OX_RESP_ERR;
      arready_ff <= ~nxt_rvalid;
      rvalid_ff  <= nxt_rvalid;
      if (rd_acc) begin
        rresp_ff <= map_ok(S_AXI_ARADDR) ? `E1OX_RESP_OK : `E1OX_RESP_ERR;
        rdata_ff <= 32'h0;
        case ({S_AXI_ARADDR[`E1OX_AW-1:2], 2'b00})
          `E1OX_A_CTRL:   rdata_ff <= {27'h0, ctrl_ff};
          `E1OX_A_STAT:   rdata_ff <= {24'h0, stat_ff};
          `E1OX_A_FLAG0:  rdata_ff <= {24'h0, flag0_ff};
          `E1OX_A_ENA0:   rdata_ff <= {24'h0, ena0_ff};
          `E1OX_A_FLAG1:  rdata_ff <= {11'h0, flag1_ff};
          `E1OX_A_ENA1:   rdata_ff <= {11'h0, ena1_ff};
          `E1OX_A_OVH:    rdata_ff <= {20'h0, y_ff, x_ff, sa_ff, a_ff, si_ff};
          `E1OX_A_SA6IND: rdata_ff <= {27'h0, sa6ind_ff};
          default: begin
            if (S_AXI_ARADDR >= `E1OX_A_CW4 && map_ok(S_AXI_ARADDR)) begin
              rdata_ff <= {28'h0, cw_ff[3'(S_AXI_ARADDR[4:2])]};
            end
          end
        endcase
      end
    end
  end

  // control and enable registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_ff <= '0;
      ena0_ff <= '0;
      ena1_ff <= '0;
    end else if (CE && do_wr) begin
      case ({aw_addr_ff[`E1OX_AW-1:2], 2'b00})
        `E1OX_A_CTRL: ctrl_ff <= (ctrl_ff & ~lmask[`E1OX_CTRL_W-1:0]) |
                                 wmask[`E1OX_CTRL_W-1:0];
        `E1OX_A_ENA0: ena0_ff <= (ena0_ff & ~lmask[7:0]) | wmask[7:0];
        `E1OX_A_ENA1: ena1_ff <= (ena1_ff & ~lmask[`E1OX_F1_W-1:0]) |
                                 wmask[`E1OX_F1_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      stat_ff   <= '0;
      flag0_ff  <= '0;
      flag1_ff  <= '0;
      sa6ind_ff <= '0;
      int_n_ff  <= 1'b1;
    end else if (CE) begin
      stat_ff   <= stat_now;
      flag0_ff  <= (flag0_ff & ~((aw_addr_ff == `E1OX_A_FLAG0) ? wmask[7:0] : 8'h0)) |
                   (stat_now ^ stat_ff);
      flag1_ff  <= (flag1_ff & ~((aw_addr_ff == `E1OX_A_FLAG1) ?
                   wmask[`E1OX_F1_W-1:0] : {`E1OX_F1_W{1'b0}})) | ev1;
      sa6ind_ff <= (sa6ind_ff & ~((aw_addr_ff == `E1OX_A_SA6IND) ? wmask[4:0] : 5'h0)) |
                   sa6_hit;
      int_n_ff  <= ~(|(flag0_ff & ena0_ff) | |(flag1_ff & ena1_ff));
    end
  end

  assign INT_N         = int_n_ff;
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY  = wready_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign S_AXI_RDATA   = rdata_ff;

endmodule : e1ox_overhead

// *** verif/e1ox_assertions.sv ***
// bus and interrupt pin checker for the overhead block
`include "e1ox_params.svh"
module e1ox_checker (
  input wire logic                REF_CLK,
  input wire logic                RST,
  input wire logic                INT_N,
  input wire logic [`E1OX_AW-1:0] S_AXI_AWADDR,
  input wire logic                S_AXI_AWVALID,
  input wire logic                S_AXI_AWREADY,
  input wire logic                S_AXI_WVALID,
  input wire logic                S_AXI_WREADY,
  input wire logic [1:0]          S_AXI_BRESP,
  input wire logic                S_AXI_BVALID,
  input wire logic                S_AXI_BREADY,
  input wire logic [`E1OX_AW-1:0] S_AXI_ARADDR,
  input wire logic                S_AXI_ARVALID,
  input wire logic                S_AXI_ARREADY,
  input wire logic [31:0]         S_AXI_RDATA,
  input wire logic [1:0]          S_AXI_RRESP,
  input wire logic                S_AXI_RVALID,
  input wire logic                S_AXI_RREADY
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  logic wr_go;
  // only same-edge address and data acceptance is timed here
  assign wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  a_write_answer: assert property (wr_go |-> ##2 S_AXI_BVALID)
    else $error("write answer not on time");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped early");
  a_wr_refused: assert property (wr_go && S_AXI_AWADDR > 8'h30 |->
    ##2 S_AXI_BRESP == `E1OX_RESP_ERR) else $error("unmapped write not refused");
  a_wr_accepted: assert property (wr_go && S_AXI_AWADDR <= 8'h30 && S_AXI_AWADDR[1:0] == 2'h0
    |-> ##2 S_AXI_BRESP == `E1OX_RESP_OK) else $error("mapped write refused");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID && !S_AXI_ARREADY) else $error("read answer not on time");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped early");
  a_rd_refused: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h30 |=>
    S_AXI_RRESP == `E1OX_RESP_ERR && S_AXI_RDATA == 32'h0) else $error("unmapped read");
  a_int_quiet: assert property (!RST && $past(RST) |-> INT_N)
    else $error("interrupt active after reset");
  a_int_release: assert property ($rose(INT_N) |-> $past(S_AXI_BVALID))
    else $error("interrupt released without host write");
endmodule : e1ox_checker
bind e1ox_overhead e1ox_checker u_chk (
  .REF_CLK(REF_CLK), .RST(RST), .INT_N(INT_N), .S_AXI_AWADDR(S_AXI_AWADDR),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// *** verif/e1ox_line_model.sv ***
// aligned e1 receive stream source, ts0 and ts16 bytes set by the bench
module e1ox_line_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic [7:0] fas_byte,
  input  wire logic [7:0] nfas_byte,
  input  wire logic [7:0] cas0_byte,
  input  wire logic [7:0] cas_byte,
  output logic            rx_bit,
  output logic            rx_valid,
  output logic [4:0]      ts,
  output logic [2:0]      bitpos,
  output logic [3:0]      fnum
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cur;
  always_comb begin
    if (ts == 5'h00)
      cur = fnum[0] ? nfas_byte : fas_byte;
    else if (ts == 5'h10)
      cur = (fnum == 4'h0) ? cas0_byte : cas_byte;
    else
      cur = {3'h5, ts};
  end
  // idle cycles carry the inverted bit so nothing stale looks valid
  assign rx_bit = cur[3'h7 - bitpos] ^ !rx_valid;
  always_ff @(posedge clk) begin
    if (rst) begin
      {fnum, ts, bitpos} <= 12'h000;
      rx_valid <= 1'b0;
    end else begin
      if (rx_valid)
        {fnum, ts, bitpos} <= {fnum, ts, bitpos} + 12'h001;
      rx_valid <= slow ? !rx_valid : 1'b1;
    end
  end
endmodule : e1ox_line_model

// *** verif/e1ox_overhead_tb_top.sv ***
// testbench for the overhead block: bus tasks, stream traffic and checks
module e1ox_overhead_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst, floss, slow, aw_v, w_v, b_r, ar_v, r_r;
  logic        rx_bit, rx_v, int_n, awr, wr, bv, arr, rv;
  logic [3:0]  st, fn;
  logic [6:0]  ev;
  logic [4:0]  ts;
  logic [2:0]  bp;
  logic [1:0]  br, rr, resp;
  logic [7:0]  fas_b, nfas_b, cas0_b, aw_a, ar_a;
  logic [31:0] wd, rdata, rd_v;
  logic [3:0]  cw_e [5] = '{4'hF, 4'h0, 4'hF, 4'hF, 4'h0};
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  e1ox_line_model u_line (.clk(clk), .rst(rst), .slow(slow), .fas_byte(fas_b),
    .nfas_byte(nfas_b), .cas0_byte(cas0_b), .cas_byte(8'hFF), .rx_bit(rx_bit),
    .rx_valid(rx_v), .ts(ts), .bitpos(bp), .fnum(fn));
  e1ox_overhead u_dut (.REF_CLK(clk), .RST(rst), .CE(1'b1), .RX_BIT(rx_bit),
    .RX_BIT_VALID(rx_v), .FRM_TS(ts), .FRM_BITPOS(bp), .FRM_NUM(fn), .FRAME_LOSS(floss),
    .CRC_MF_LOSS(floss), .INTERWORK(st[0]), .OFFLINE_SEARCH(st[1]), .CONT_RAI_FEBE(st[2]),
    .CONT_FEBE(st[3]), .ALIGN_CHANGE(ev[0]), .FAS_ERR(ev[1]), .CRC_PAT_ERR(ev[2]),
    .CRC4_ERR(ev[3]), .FEBE_ERR(ev[4]), .NT_FEBE_ERR(ev[5]), .NT_CRC_ERR(ev[6]),
    .INT_N(int_n), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_a),
    .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(r_r));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // run is about 47k cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    aw_a <= a;
    wd <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) aw_v <= 1'b0;
      if (wr) w_v <= 1'b0;
    end while ((aw_v && !awr) || (w_v && !wr));
    while (!bv) @(posedge clk);
    // late ready keeps the response waiting a cycle on purpose
    b_r <= 1'b1;
    @(posedge clk);
    resp = br;
    b_r <= 1'b0;
  endtask : wr32
  task automatic rd32(input logic [7:0] a);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    do @(posedge clk); while (!arr);
    ar_v <= 1'b0;
    while (!rv) @(posedge clk);
    r_r <= 1'b1;
    @(posedge clk);
    rd_v = rdata;
    resp = rr;
    r_r <= 1'b0;
  endtask : rd32
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string n);
    rd32(a);
    chk(n, e, rd_v & m);
  endtask : rchk
  task automatic wait_fr(input int n);
    repeat (n) begin
      @(posedge clk);
      while (!(rx_v && ts == 5'h1F && bp == 3'h7)) @(posedge clk);
    end
  endtask : wait_fr
  initial begin
    rst = 1'b1;
    {floss, slow, aw_v, w_v, b_r, ar_v, r_r} = 7'h00;
    {st, ev, aw_a, ar_a, wd} = '0;
    fas_b = 8'h1B;
    nfas_b = 8'hD6;
    cas0_b = 8'h0D;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("int_n", 32'h1, {31'h0, int_n});
    rchk(8'h00, 32'h1F, 32'h0, "ctrl");
    rchk(8'h34, 32'hFFFFFFFF, 32'h0, "unmapped data");
    chk("read resp", 32'h2, {30'h0, resp});
    wr32(8'h40, 32'hFFFFFFFF);
    chk("write resp", 32'h2, {30'h0, resp});
    wait_fr(48);
    rchk(8'h18, 32'hFFF, 32'hDB2, "overhead");
    rchk(8'h04, 32'h0E, 32'h0, "status aligned");
    for (int i = 0; i < 5; i++)
      rchk(8'h20 + 8'(i * 4), 32'hF, {28'h0, cw_e[i]}, "codeword");
    rchk(8'h10, 32'h001F0F00, 32'h000D0F00, "flag1");
    rchk(8'h1C, 32'h1F, 32'h10, "sa6 code");
    wr32(8'h14, 32'h00010000);
    repeat (2) @(posedge clk);
    chk("int_n", 32'h0, {31'h0, int_n});
    wr32(8'h10, 32'h00010000);
    repeat (2) @(posedge clk);
    chk("int_n", 32'h1, {31'h0, int_n});
    rchk(8'h10, 32'h00010000, 32'h0, "flag1 cleared");
    ev <= 7'h7F;
    st <= 4'hF;
    @(posedge clk);
    ev <= 7'h00;
    rchk(8'h04, 32'h71, 32'h71, "status up");
    rchk(8'h10, 32'hF7, 32'hF7, "flag1 events");
    wr32(8'h08, 32'h71);
    rchk(8'h08, 32'h71, 32'h0, "flag0 cleared");
    st <= 4'h0;
    rchk(8'h08, 32'h71, 32'h71, "flag0 fall");
    floss <= 1'b1;
    nfas_b <= 8'h2A;
    cas0_b <= 8'h02;
    wait_fr(4);
    rchk(8'h04, 32'h0E, 32'h0E, "status loss");
    rchk(8'h18, 32'hFFF, 32'hDB2, "overhead held");
    floss <= 1'b0;
    slow <= 1'b1;
    nfas_b <= 8'hD4;
    wait_fr(48);
    rchk(8'h18, 32'hF00, 32'h200, "ts16 spare");
    rchk(8'h04, 32'h8E, 32'h80, "status link");
    rchk(8'h08, 32'h80, 32'h80, "flag0 link");
    wr32(8'h00, 32'h1F);
    rchk(8'h00, 32'h1F, 32'h1F, "ctrl");
    slow <= 1'b0;
    cas0_b <= 8'h80;
    wait_fr(17);
    rchk(8'h04, 32'h08, 32'h08, "cas lost");
    rchk(8'h10, 32'h08, 32'h08, "cas pattern error");
    wr32(8'h10, 32'h08);
    wait_fr(17);
    rchk(8'h10, 32'h08, 32'h0, "no error while lost");
    end_of_test();
  end
endmodule : e1ox_overhead_tb_top
